// ===== hw/als_pkg.sv
// Purpose: shared constants for the ambient light conversion and readout block
// Assumes: 25 MHz system clock, two-wire bus pins sampled through synchronisers
// Notes:   cycle counts are derived here from the printed times and the clock rate
// Function
// [R01] The host selects the light result by writing bus byte 26h then pointer 85h.
// [R02] A read at bus byte 27h after that returns the high result byte.
// [R03] A further read at bus byte 27h returns the low result byte at pointer 86h.
// [R04] With continuous mode off, each result is made within a fixed 100 ms frame.
// [R05] Each single conversion takes about 300 us, leaving the rest of the frame idle.
// [R06] The result is the average of the configured number of conversions, up to 128.
// [R07] In standard mode a new result appears only when the 100 ms frame ends.
// [R08] With continuous mode on, each conversion starts right after the previous one.
// [R09] The register pointer advances by one after each byte read.
// [R10] Either a stop and new start or a repeated start may precede the read.
// [R11] In continuous mode the result updates as soon as the averaged set is complete.
package als_pkg;

	localparam int          CLK_HZ      = 25_000_000;
	localparam int          FRAME_MS    = 100;
	localparam int          CONV_US     = 300;
	localparam int          FRAME_CYC   = FRAME_MS * (CLK_HZ / 1000);
	localparam int          CONV_CYC    = (CONV_US * (CLK_HZ / 1000) + 999) / 1000;

	localparam logic [7:0]  BUS_WR_ADDR = 8'h26;
	localparam logic [7:0]  BUS_RD_ADDR = 8'h27;
	localparam logic [7:0]  PTR_RES_HI  = 8'h85;
	localparam logic [7:0]  PTR_RES_LO  = 8'h86;
	localparam logic [7:0]  PTR_RST     = 8'h00;
	localparam logic [15:0] RESULT_RST  = 16'h0000;
	localparam logic [2:0]  AVG_MAX_LOG = 3'h7;
	localparam logic [3:0]  BITS_BYTE   = 4'h8;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b010,
		ST_PTR  = 3'b011,
		ST_PACK = 3'b100,
		ST_TX   = 3'b101,
		ST_HACK = 3'b110
	} bus_state_e;

	typedef enum logic {
		SQ_CONV = 1'b0,
		SQ_WAIT = 1'b1
	} seq_state_e;

endpackage

// ===== hw/conv_if.sv
// Purpose: carries the averaged result and the sequencer settings between modules
// Assumes: single clock domain
// Notes:   result_valid is a one-cycle pulse with result stable from then on
`timescale 1ns/1ns
interface conv_if;
	logic [15:0] result;
	logic        result_valid;
	logic        cont_mode;
	logic [2:0]  avg_log2;

	modport seq (output result, output result_valid, input cont_mode, input avg_log2);
	modport rd  (input result, input result_valid, output cont_mode, output avg_log2);
endinterface

// ===== hw/als_sequencer.sv
// Purpose: paces single conversions and averages them into one light result
// Assumes: adc_sample is valid in the cycle a conversion slot ends, same clock domain
// Notes:   standard mode runs the set at the frame start, publishes at frame end
`timescale 1ns/1ns
module als_sequencer
	import als_pkg::*;
#(
	parameter int FRAME_CYCLES = FRAME_CYC,
	parameter int CONV_CYCLES  = CONV_CYC
) (
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic [15:0] adc_sample,
	conv_if.seq              cv
);

	seq_state_e  state_q, state_d;
	logic [21:0] frame_q, frame_d;
	logic [12:0] conv_q,  conv_d;
	logic [7:0]  done_q,  done_d;
	logic [22:0] acc_q,   acc_d;
	logic [15:0] res_q,   res_d;
	logic        vld_q,   vld_d;
	logic [22:0] acc_sum;
	logic [7:0]  n_target;
	logic        conv_end, frame_end;

	// divide the accumulated sum by the power-of-two count
	function automatic logic [15:0] avg_of(input logic [22:0] sum, input logic [2:0] sh);
		avg_of = 16'(sum >> sh);
	endfunction

	assign n_target  = 8'(9'h001 << cv.avg_log2); // [R06]
	assign acc_sum   = acc_q + {7'h00, adc_sample};
	assign conv_end  = (state_q == SQ_CONV) && (conv_q == 13'(CONV_CYCLES - 1)); // [R05]
	assign frame_end = (frame_q == 22'(FRAME_CYCLES - 1)); // [R04]

	////////////////////////////////////////////////////////////////////////////
	// next values: conversion slots, averaging and frame pacing
	always_comb begin
		state_d = state_q;
		frame_d = cv.cont_mode ? 22'h000000 : (frame_end ? 22'h000000 : frame_q + 22'h000001);
		conv_d  = conv_q;
		done_d  = done_q;
		acc_d   = acc_q;
		res_d   = res_q;
		vld_d   = 1'b0;
		if (state_q == SQ_CONV) begin
			conv_d = conv_end ? 13'h0000 : conv_q + 13'h0001; // [R08]
		end
		if (conv_end) begin
			if (done_q + 8'h01 >= n_target) begin
				if (cv.cont_mode) begin
					res_d  = avg_of(acc_sum, cv.avg_log2); // [R11]
					vld_d  = 1'b1;
					acc_d  = 23'h000000;
					done_d = 8'h00;
				end else begin
					acc_d   = acc_sum;
					done_d  = done_q + 8'h01;
					state_d = SQ_WAIT;
				end
			end else begin
				acc_d  = acc_sum;
				done_d = done_q + 8'h01;
			end
		end
		// frame end publishes the waiting set and restarts; leaving standard mode
		// while waiting resumes conversions straight away
		if (state_q == SQ_WAIT && (frame_end || cv.cont_mode)) begin
			res_d   = avg_of(acc_q, cv.avg_log2); // [R07]
			vld_d   = 1'b1;
			acc_d   = 23'h000000;
			done_d  = 8'h00;
			conv_d  = 13'h0000;
			state_d = SQ_CONV;
		end
	end

	// state registers only
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= SQ_CONV;
			frame_q <= 22'h000000;
			conv_q  <= 13'h0000;
			done_q  <= 8'h00;
			acc_q   <= 23'h000000;
			res_q   <= RESULT_RST;
			vld_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			frame_q <= frame_d;
			conv_q  <= conv_d;
			done_q  <= done_d;
			acc_q   <= acc_d;
			res_q   <= res_d;
			vld_q   <= vld_d;
		end
	end

	assign cv.result       = res_q;
	assign cv.result_valid = vld_q;

endmodule // als_sequencer

// ===== hw/als_readout.sv
// Purpose: two-wire bus target returning the averaged light result, plus sequencer
// Assumes: bus pins are asynchronous; cont_mode and avg_log2 come from same-clock logic
// Notes:   open-drain data pin: sda_o is held low and sda_oe pulls the line
`timescale 1ns/1ns
module als_readout
	import als_pkg::*;
#(
	parameter int FRAME_CYCLES = FRAME_CYC,
	parameter int CONV_CYCLES  = CONV_CYC
) (
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	input  wire logic        cont_mode,
	input  wire logic [2:0]  avg_log2,
	input  wire logic [15:0] adc_sample,
	output logic [15:0]      result,
	output logic             result_new
);

	conv_if cv ();

	bus_state_e  state_q, state_d;
	logic [3:0]  cnt_q,   cnt_d;
	logic [7:0]  shift_q, shift_d;
	logic [7:0]  ptr_q,   ptr_d;
	logic [7:0]  tx_q,    tx_d;
	logic [15:0] snap_q,  snap_d;
	logic [15:0] res_q,   res_d;
	logic        oe_q,    oe_d;
	logic        rd_q,    rd_d;
	logic        new_q,   new_d;
	logic        scl_s1_q, scl_s2_q, scl_s3_q;
	logic        sda_s1_q, sda_s2_q, sda_s3_q;
	logic        start, stop, scl_rise, scl_fall;

	// byte returned for a pointer; unmapped pointers read as zero
	function automatic logic [7:0] read_byte(input logic [7:0] ptr, input logic [15:0] val);
		if (ptr == PTR_RES_HI) begin
			read_byte = val[15:8]; // [R02]
		end else if (ptr == PTR_RES_LO) begin
			read_byte = val[7:0]; // [R03]
		end else begin
			read_byte = 8'h00;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// conversion sequencer
	assign cv.cont_mode = cont_mode;
	assign cv.avg_log2  = (avg_log2 > AVG_MAX_LOG) ? AVG_MAX_LOG : avg_log2; // [R06]

	als_sequencer #(
		.FRAME_CYCLES (FRAME_CYCLES),
		.CONV_CYCLES  (CONV_CYCLES)
	) u_seq (
		.clock      (clock),
		.arst_n     (arst_n),
		.adc_sample (adc_sample),
		.cv         (cv)
	);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; third stage only feeds edge detection
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
		end else begin
			scl_s1_q <= scl_i;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= sda_i;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
		end
	end

	// bus conditions from the synchronised lines
	assign scl_rise = scl_s2_q & ~scl_s3_q;
	assign scl_fall = ~scl_s2_q & scl_s3_q;
	assign start    = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q; // [R10]
	assign stop     = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

	////////////////////////////////////////////////////////////////////////////
	// bus target next values
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		shift_d = shift_q;
		ptr_d   = ptr_q;
		tx_d    = tx_q;
		snap_d  = snap_q;
		oe_d    = oe_q;
		rd_d    = rd_q;
		// a start from any state, stop or not, begins a new address phase
		if (start) begin
			state_d = ST_ADDR; // [R10]
			cnt_d   = 4'h0;
			oe_d    = 1'b0;
		end else if (stop) begin
			state_d = ST_IDLE;
			oe_d    = 1'b0;
		end else if (scl_rise) begin
			case (state_q)
				ST_ADDR, ST_PTR: begin
					shift_d = {shift_q[6:0], sda_s2_q};
					cnt_d   = cnt_q + 4'h1;
				end
				ST_HACK: begin
					if (sda_s2_q) begin
						state_d = ST_IDLE; // host not-ack ends the read
					end
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state_q)
				ST_ADDR: begin
					if (cnt_q == BITS_BYTE) begin
						if (shift_q == BUS_WR_ADDR || shift_q == BUS_RD_ADDR) begin // [R01]
							state_d = ST_AACK;
							oe_d    = 1'b1;
							rd_d    = shift_q[0];
						end else begin
							state_d = ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					if (rd_q) begin
						// snapshot keeps high and low bytes of one result together
						snap_d  = res_q;
						tx_d    = read_byte(ptr_q, res_q); // [R02]
						oe_d    = ~tx_d[7]; // pull the line for a zero bit
						state_d = ST_TX;
					end else begin
						oe_d    = 1'b0;
						state_d = ST_PTR;
					end
					cnt_d = 4'h0;
				end
				ST_PTR: begin
					if (cnt_q == BITS_BYTE) begin
						ptr_d   = shift_q; // [R01]
						oe_d    = 1'b1;
						state_d = ST_PACK;
					end
				end
				ST_PACK: begin
					// no writable registers: later data bytes are not acknowledged
					oe_d    = 1'b0;
					state_d = ST_IDLE;
				end
				ST_TX: begin
					if (cnt_q == 4'h7) begin
						oe_d    = 1'b0;
						ptr_d   = ptr_q + 8'h01; // [R09]
						state_d = ST_HACK;
					end else begin
						tx_d  = {tx_q[6:0], 1'b0};
						oe_d  = ~tx_q[6];
						cnt_d = cnt_q + 4'h1;
					end
				end
				ST_HACK: begin
					tx_d    = read_byte(ptr_q, snap_q); // [R03]
					oe_d    = ~tx_d[7]; // pull the line for a zero bit
					cnt_d   = 4'h0;
					state_d = ST_TX;
				end
				default: begin
				end
			endcase
		end
	end

	// result register and update pulse
	always_comb begin
		res_d = cv.result_valid ? cv.result : res_q;
		new_d = cv.result_valid;
	end

	// registers only
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_IDLE;
			cnt_q   <= 4'h0;
			shift_q <= 8'h00;
			ptr_q   <= PTR_RST;
			tx_q    <= 8'h00;
			snap_q  <= RESULT_RST;
			res_q   <= RESULT_RST;
			oe_q    <= 1'b0;
			rd_q    <= 1'b0;
			new_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			shift_q <= shift_d;
			ptr_q   <= ptr_d;
			tx_q    <= tx_d;
			snap_q  <= snap_d;
			res_q   <= res_d;
			oe_q    <= oe_d;
			rd_q    <= rd_d;
			new_q   <= new_d;
		end
	end

	assign sda_o      = 1'b0;
	assign sda_oe     = oe_q;
	assign result     = res_q;
	assign result_new = new_q;

endmodule // als_readout

// ===== tb/als_readout_sva.sv
// Purpose: port level checks for the light readout block
// Assumes: one clock domain, asynchronous active low reset
// Notes:   period checks skip the first pulse after a settings change
`timescale 1ns/1ns
module als_readout_sva
	import als_pkg::*;
#(
	parameter int FRAME_CYCLES = FRAME_CYC,
	parameter int CONV_CYCLES  = CONV_CYC
) (
	input wire logic        clock,
	input wire logic        arst_n,
	input wire logic        scl_i,
	input wire logic        sda_i,
	input wire logic        sda_o,
	input wire logic        sda_oe,
	input wire logic        cont_mode,
	input wire logic [2:0]  avg_log2,
	input wire logic [15:0] adc_sample,
	input wire logic [15:0] result,
	input wire logic        result_new
);
	int         gap_q, gap_d;
	logic       ok_q, ok_d, cm_q;
	logic [2:0] av_q;
	//////////////////////////////////////////////////////////////////////
	// cycles since last pulse; a settings change voids one period
	always_comb begin
		gap_d = result_new ? 1 : gap_q + 1;
		ok_d = (cont_mode != cm_q || avg_log2 != av_q) ? 1'b0 : (result_new | ok_q);
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gap_q <= 0;
			ok_q  <= 1'b0;
			cm_q  <= 1'b0;
			av_q  <= 3'h0;
		end else begin
			gap_q <= gap_d;
			ok_q  <= ok_d;
			cm_q  <= cont_mode;
			av_q  <= avg_log2;
		end
	end
	//////////////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence ack_hold_s;
		sda_oe [*4];
	endsequence
	sequence low_seen_s;
		!scl_i && ($past(scl_i, 2) == 1'b0);
	endsequence
	pulse_once_a: assert property (result_new |=> !result_new)
		else $error("result pulse longer than one cycle");
	result_hold_a: assert property (!result_new |-> $stable(result))
		else $error("result moved without a pulse");
	cont_period_a: assert property (result_new && cont_mode && ok_q
		|-> gap_q == (CONV_CYCLES << avg_log2)) else $error("continuous period wrong");
	frame_period_a: assert property (result_new && !cont_mode && ok_q
		|-> gap_q == FRAME_CYCLES) else $error("frame period wrong");
	sda_low_a: assert property (sda_o == 1'b0)
		else $error("data pin driven high");
	drive_phase_a: assert property ($rose(sda_oe) |-> low_seen_s)
		else $error("data drive began outside clock low");
	ack_hold_a: assert property ($rose(sda_oe) |-> ack_hold_s)
		else $error("data drive too short");
	scl_stable_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
		else $error("data changed while clock high");
endmodule // als_readout_sva

bind als_readout als_readout_sva #(.FRAME_CYCLES(FRAME_CYCLES), .CONV_CYCLES(CONV_CYCLES)) chk (
	.clock(clock), .arst_n(arst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe(sda_oe), .cont_mode(cont_mode), .avg_log2(avg_log2),
	.adc_sample(adc_sample), .result(result), .result_new(result_new));

// ===== tb/bus_host.sv
// Purpose: behavioural two-wire bus host reading light results
// Assumes: line has a pull-up; phases of 10 low and 8 high clock cycles
// Notes:   wide low phase leaves room for the target's synchroniser lag
`timescale 1ns/1ns
module bus_host (
	input  wire logic clock,
	input  wire logic sda_in,
	output logic      scl,
	output logic      sda_rel
);
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// one clock pulse, data set while low, sampled mid high
	task automatic bit_io(input logic b, output logic r);
		sda_rel <= b;
		tick(10);
		scl <= 1'b1;
		tick(4);
		r = sda_in;
		tick(4);
		scl <= 1'b0;
	endtask
	// also serves as repeated start when clock is low
	task automatic start;
		sda_rel <= 1'b1;
		tick(10);
		scl <= 1'b1;
		tick(8);
		sda_rel <= 1'b0;
		tick(8);
		scl <= 1'b0;
	endtask
	task automatic stop;
		sda_rel <= 1'b0;
		tick(10);
		scl <= 1'b1;
		tick(8);
		sda_rel <= 1'b1;
		tick(8);
	endtask
	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rd(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(!ack, r);
	endtask
endmodule // bus_host

// ===== tb/ambient_light_conversion_readout_tb.sv
// Purpose: self-checking bench for the light readout block
// Assumes: small frame and conversion counts keep the run short
// Notes:   two samples alternate each slot so an even average differs from both
`timescale 1ns/1ns
`define CHK(a, e, m) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("BAD %0t %s", $time, m); end end
module ambient_light_conversion_readout_tb;
	localparam int          FRAME_C = 200;
	localparam int          CONV_C  = 10;
	localparam logic [15:0] S0      = 16'hA53C;
	localparam logic [15:0] S1      = 16'h1234;
	localparam logic [15:0] S_AVG   = 16'((17'(S0) + 17'(S1)) >> 1);
	logic        clock = 1'b0, arst_n = 1'b0, scl, sda_rel, sda_o, sda_oe, result_new;
	logic        cont_mode = 1'b0;
	logic [2:0]  avg_log2 = 3'h2;
	logic [15:0] smp_a = S0, smp_b = S1, result;
	logic        ph = 1'b0;
	int          ph_cnt = 0;
	int          n_mismatch = 0, total_checks = 0, cyc = 0;
	wire         sda_line = sda_rel & (~sda_oe | sda_o);
	wire  [15:0] adc_sample = ph ? smp_b : smp_a;
	als_readout #(.FRAME_CYCLES(FRAME_C), .CONV_CYCLES(CONV_C)) DUT (.clock(clock),
		.arst_n(arst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
		.cont_mode(cont_mode), .avg_log2(avg_log2), .adc_sample(adc_sample),
		.result(result), .result_new(result_new));
	bus_host host (.clock(clock), .sda_in(sda_line), .scl(scl), .sda_rel(sda_rel));
	initial begin
		forever #20 clock = ~clock;
	end
	// swap samples every slot: samples one slot apart differ except in the single-sample
	// set of t_cont, so a lost sum or a wrong shift shows whatever the slot phase is
	always @(posedge clock) begin
		ph_cnt <= (ph_cnt == CONV_C - 1) ? 0 : ph_cnt + 1;
		if (ph_cnt == CONV_C - 1) ph <= ~ph;
	end
	//////////////////////////////////////////////////////////////////////
	task automatic summarize;
		if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// hang guard, well above the expected run length
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			summarize;
		end
	end
	task automatic wait_pulse;
		int k;
		k = 0;
		do begin
			@(negedge clock);
			k++;
		end while (result_new !== 1'b1 && k < 3000);
		`CHK(result_new, 1'b1, "no result pulse")
	endtask
	//////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		@(negedge clock);
		`CHK(result, 16'h0000, "result before first frame")
		`CHK(sda_oe, 1'b0, "bus driven at idle")
	endtask
	task automatic t_frame;
		int t0;
		wait_pulse;
		t0 = cyc;
		wait_pulse;
		`CHK(cyc - t0, FRAME_C, "frame length")
		`CHK(result, S_AVG, "standard average")
	endtask
	task automatic t_read(input logic rep);
		logic       a;
		logic [7:0] h, l;
		host.start;
		host.wr(8'h26, a);
		`CHK(a, 1'b1, "write address ack")
		host.wr(8'h85, a);
		`CHK(a, 1'b1, "pointer ack")
		if (!rep) host.stop;
		host.start;
		host.wr(8'h27, a);
		`CHK(a, 1'b1, "read address ack")
		host.rd(1'b1, h);
		`CHK(h, S_AVG[15:8], "high byte")
		host.rd(1'b0, l);
		`CHK(l, S_AVG[7:0], "low byte")
		host.stop;
		host.start;
		host.wr(8'h27, a);
		host.rd(1'b0, h);
		`CHK(h, 8'h00, "pointer past low byte")
		host.stop;
	endtask
	// unknown target byte: no acknowledge expected
	task automatic t_refuse;
		logic a;
		host.start;
		host.wr(8'h30, a);
		`CHK(a, 1'b0, "foreign address acked")
		host.stop;
	endtask
	// every averaging count in back-to-back mode, settled period measured
	task automatic t_cont;
		int          t0;
		logic [15:0] want;
		for (logic [3:0] a = 4'h0; a < 4'h8; a++) begin
			@(posedge clock);
			cont_mode <= 1'b1;
			avg_log2 <= a[2:0];
			smp_a <= {8'hC3, 5'h00, a[2:0]};
			// a single-sample set would depend on slot phase, so both match there
			smp_b <= (a == 4'h0) ? {8'hC3, 5'h00, a[2:0]} : {8'h41, 5'h00, a[2:0]};
			wait_pulse;
			wait_pulse;
			t0 = cyc;
			wait_pulse;
			`CHK(cyc - t0, CONV_C << a, "continuous period")
			want = 16'((17'(smp_a) + 17'(smp_b)) >> 1);
			`CHK(result, want, "continuous average")
		end
	endtask
	initial begin
		repeat (20) @(posedge clock);
		arst_n <= 1'b1;
		t_reset;
		t_frame;
		t_read(1'b0);
		t_read(1'b1);
		t_refuse;
		t_cont;
		summarize;
	end
endmodule // ambient_light_conversion_readout_tb
